// file: logic/adc_route_decode.sv
// Decode of the channel/gain code into input routing and gain
`default_nettype none
module adc_route_decode (
  input  wire logic [4:0]            code,  // Channel/gain select code
  output var  adc_sel_pkg::route_type route  // Decoded routing
);
  import adc_sel_pkg::*;

  always_comb begin
    route = '{differential: 1'b0, pos_input: code[2:0], neg_input: IN_0, gain: GAIN_X1, source: SRC_PIN};
    if (code <= CH_LAST_SINGLE) begin
      route.source = SRC_PIN;
    end else if (code == CH_BANDGAP) begin
      route.source = SRC_BANDGAP;
    end else if (code == CH_GROUND) begin
      route.source = SRC_GROUND;
    end else if (code < CH_FIRST_VS1) begin
      // Gain pairs against input 0 or 2
      route.differential = 1'b1;
      route.neg_input    = code[2] ? IN_2 : IN_0;
      route.pos_input    = code[2] ? (code[0] ? 3'h3 : IN_2) : (code[0] ? IN_1 : IN_0);
      route.gain         = code[1] ? GAIN_X200 : GAIN_X10;
    end else if (code < CH_FIRST_VS2) begin
      route.differential = 1'b1;
      route.neg_input    = IN_1;
    end else begin
      route.differential = 1'b1;
      route.neg_input    = IN_2;
    end
  end
endmodule : adc_route_decode
`default_nettype wire

// file: logic/adc_sel_core.sv
// Converter input selection, result formatting and APB register file
// Operation
// - Result becomes readable only when conversion completes and the done flag sets.
// - Single-ended results are unsigned ten-bit codes, ground to reference minus one step.
// - Differential results are ten-bit two's complement, 0x200 to 0x1FF.
// - Sign of a differential result sits in the top result bit.
// - Reference field 7:6 selects pin, supply, 1.1V or 2.56V reference.
// - Reference and channel changes during a conversion apply from the next one.
// - Left-adjust bit 5 remaps the readable result at once, even mid-conversion.
// - Codes 0-7 select single inputs; 30 bandgap, 31 ground.
// - Codes 8 to 29 select differential pairs with their gains.
// - Left adjust puts bits 9:2 high, 1:0 low-top; else right aligned.
// - Reading the low byte blocks result updates until the high byte is read.
//
// Our own choice: the APB register port.
`default_nettype none
module adc_sel_core #(
  parameter int ADDR_W = 10  // APB byte address width
) (
  input  wire logic                     core_clk,    // System clock
  input  wire logic                     nrst,        // Asynchronous reset, active low
  input  wire adc_sel_pkg::apb_req_type apb_req,     // APB request
  output var  adc_sel_pkg::apb_rsp_type apb_rsp,     // APB response
  input  wire logic                     sar_done,    // Converter finished, one-cycle pulse
  input  wire logic [9:0]               sar_code,    // Raw code, offset binary when differential
  output logic                          conv_start,  // Start pulse to converter
  output logic [1:0]                    ref_select,  // Reference used by the running conversion
  output var  adc_sel_pkg::route_type   route,       // Input routing of the running conversion
  output logic                          irq          // Interrupt, level
);
  import adc_sel_pkg::*;

  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  function automatic logic [15:0] present(input logic [RES_W-1:0] r, input logic left);
    present = left ? {r[9:2], r[1:0], 6'h00} : {6'h00, r[9:8], r[7:0]};
  endfunction : present

  function automatic logic [7:0] index_of(input logic [9:0] a);
    index_of = a[9:2];
  endfunction : index_of

  logic [7:0]       input_select_q;
  logic [RES_W-1:0] result_q;
  logic             lock_q;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] mask_q;
  logic             busy_q;
  conv_state_type   state_q;
  route_type        route_d;
  logic [15:0]      view;
  logic [7:0]       idx;
  logic             setup_ph;
  logic             xfer;
  logic             wr_en;
  logic             rd_en;
  logic             start_req;
  logic             done_evt;
  logic             store_evt;
  logic             low_rd;
  logic             held;
  logic [RES_W-1:0] formatted;

  adc_route_decode u_decode (
    .code  (input_select_q[CHAN_HI:0]),
    .route (route_d)
  );

  assign idx       = index_of(apb_req.paddr);
  assign setup_ph  = apb_req.psel & ~apb_req.penable;
  assign xfer      = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign wr_en     = xfer & apb_req.pwrite & ~apb_rsp.pslverr;
  assign rd_en     = xfer & ~apb_req.pwrite & ~apb_rsp.pslverr;
  assign start_req = wr_en & (idx == IDX_CONTROL) & apb_req.pwdata[CTRL_START_BIT];
  assign done_evt  = (state_q == ST_CONV) & sar_done;
  assign low_rd    = apb_req.psel & ~apb_req.pwrite & (idx == IDX_RESULT_LOW) & (apb_req.paddr[1:0] == 2'b00);
  // The low byte is captured at setup, so a store during that read would split the pair
  assign held      = lock_q | low_rd;
  assign store_evt = done_evt & ~held;
  assign view      = present(result_q, input_select_q[LADJ_BIT]);
  // Differential code arrives offset binary; flipping the top bit gives two's complement
  assign formatted = route.differential ? {~sar_code[9], sar_code[8:0]} : sar_code;

  // Selection register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      input_select_q <= INPUT_SELECT_RESET;
    end else if (wr_en && idx == IDX_INPUT_SELECT) begin
      input_select_q <= apb_req.pwdata[7:0];
    end
  end

  // Conversion sequencing; settings captured at start
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      busy_q     <= 1'b0;
      conv_start <= 1'b0;
      ref_select <= REF_PIN;
      route      <= '0;
    end else begin
      conv_start <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            state_q    <= ST_CONV;
            busy_q     <= 1'b1;
            conv_start <= 1'b1;
            ref_select <= input_select_q[REF_HI:REF_LO];
            route      <= route_d;
          end
        end
        ST_CONV: begin
          if (sar_done) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Result register and read lock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= '0;
    end else if (store_evt) begin
      result_q <= formatted;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= 1'b0;
    end else if (rd_en && idx == IDX_RESULT_LOW) begin
      lock_q <= 1'b1;
    end else if (rd_en && idx == IDX_RESULT_HIGH) begin
      lock_q <= 1'b0;
    end
  end

  // Sticky events; a set wins over a write-one clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      for (int i = 0; i < EVT_W; i++) begin
        if (wr_en && idx == IDX_STATUS && apb_req.pwdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
      if (store_evt) begin
        status_q[ST_DONE_BIT] <= 1'b1;
      end
      if (done_evt && held) begin
        status_q[ST_LOST_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= '0;
    end else if (wr_en && idx == IDX_MASK) begin
      mask_q <= apb_req.pwdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // APB response, one cycle after setup
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      apb_rsp <= '0;
    end else if (setup_ph) begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.pslverr <= 1'b0;
      apb_rsp.prdata  <= '0;
      if (apb_req.paddr[1:0] != 2'b00) begin
        apb_rsp.pslverr <= 1'b1;
      end else begin
        unique case (idx)
          IDX_INPUT_SELECT: apb_rsp.prdata[7:0] <= input_select_q;
          IDX_RESULT_LOW:   apb_rsp.prdata[7:0] <= view[7:0];
          IDX_RESULT_HIGH:  apb_rsp.prdata[7:0] <= view[15:8];
          IDX_CONTROL:      apb_rsp.prdata[CTRL_START_BIT] <= busy_q;
          IDX_STATUS:       apb_rsp.prdata[EVT_W-1:0] <= status_q;
          IDX_MASK:         apb_rsp.prdata[EVT_W-1:0] <= mask_q;
          default:          apb_rsp.pslverr <= 1'b1;
        endcase
      end
    end else begin
      apb_rsp.pready  <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_result_hold: assert property ($changed(result_q) |-> $past(store_evt))
    else $error("Result changed without a completed conversion");

  chk_done_with_result: assert property (store_evt |=> status_q[ST_DONE_BIT] && result_q == $past(formatted))
    else $error("Done flag and result not updated together");

  chk_single_code: assert property (store_evt && !route.differential |=> result_q == $past(sar_code))
    else $error("Single-ended result is not straight binary");

  chk_diff_twos: assert property (store_evt && route.differential
                                  |=> result_q == {~$past(sar_code[9]), $past(sar_code[8:0])})
    else $error("Differential result is not two's complement");

  chk_sign_bit: assert property (store_evt && route.differential
                                 |=> result_q[9] == ($past(sar_code) < 10'h200))
    else $error("Differential sign bit wrong");

  chk_ref_capture: assert property (state_q == ST_IDLE && start_req
                                    |=> ref_select == $past(input_select_q[7:6]) && conv_start ##1 !conv_start)
    else $error("Reference not captured at start");

  chk_settings_held: assert property (state_q == ST_CONV && $past(state_q) == ST_CONV
                                      |-> $stable(ref_select) && $stable(route))
    else $error("Settings moved during a conversion");

  chk_no_restart: assert property (state_q == ST_CONV |=> !conv_start)
    else $error("Start accepted while busy");

  chk_idle_return: assert property (state_q == ST_CONV && sar_done |=> state_q == ST_IDLE)
    else $error("Conversion did not end on done");

  chk_left_view: assert property (setup_ph && idx == IDX_RESULT_HIGH && apb_req.paddr[1:0] == 2'b00
                                  && input_select_q[LADJ_BIT]
                                  |=> apb_rsp.prdata[7:0] == $past(result_q[9:2]) && apb_rsp.pready)
    else $error("Left adjusted high byte wrong");

  chk_left_low: assert property (setup_ph && idx == IDX_RESULT_LOW && apb_req.paddr[1:0] == 2'b00
                                 && input_select_q[LADJ_BIT]
                                 |=> apb_rsp.prdata[7:0] == {$past(result_q[1:0]), 6'h00})
    else $error("Left adjusted low byte wrong");

  chk_right_view: assert property (setup_ph && idx == IDX_RESULT_LOW && apb_req.paddr[1:0] == 2'b00
                                   && !input_select_q[LADJ_BIT]
                                   |=> apb_rsp.prdata[7:0] == $past(result_q[7:0]))
    else $error("Right adjusted low byte wrong");

  chk_right_high: assert property (setup_ph && idx == IDX_RESULT_HIGH && apb_req.paddr[1:0] == 2'b00
                                   && !input_select_q[LADJ_BIT]
                                   |=> apb_rsp.prdata[7:0] == {6'h00, $past(result_q[9:8])})
    else $error("Right adjusted high byte wrong");

  chk_decode_single: assert property (input_select_q[4:3] == 2'b00 |-> !route_d.differential
                                      && route_d.pos_input == input_select_q[2:0])
    else $error("Single-ended decode wrong");

  chk_decode_fixed: assert property (input_select_q[4:1] == 4'b1111
                                     |-> !route_d.differential
                                     && route_d.source == (input_select_q[0] ? SRC_GROUND : SRC_BANDGAP))
    else $error("Bandgap or ground decode wrong");

  chk_decode_gain: assert property (input_select_q[4:3] == 2'b01 |-> route_d.differential
                                    && route_d.neg_input == (input_select_q[2] ? IN_2 : IN_0)
                                    && route_d.gain == (input_select_q[1] ? GAIN_X200 : GAIN_X10))
    else $error("Gain pair decode wrong");

  chk_decode_pair: assert property (input_select_q[4:3] == 2'b10 |-> route_d.differential
                                    && route_d.neg_input == IN_1 && route_d.gain == GAIN_X1)
    else $error("Differential decode wrong");

  chk_decode_second: assert property (input_select_q[4:3] == 2'b11 && input_select_q[4:1] != 4'b1111
                                      |-> route_d.differential && route_d.neg_input == IN_2
                                      && route_d.pos_input == input_select_q[2:0] && route_d.gain == GAIN_X1)
    else $error("Second pair decode wrong");

  chk_lock_blocks: assert property (lock_q && done_evt |=> $stable(result_q) && status_q[ST_LOST_BIT])
    else $error("Result updated while low byte read pending");

  chk_low_guard: assert property (done_evt && low_rd |=> $stable(result_q) && status_q[ST_LOST_BIT])
    else $error("Result updated during a low byte read");

  chk_busy_read: assert property (setup_ph && idx == IDX_CONTROL && apb_req.paddr[1:0] == 2'b00
                                  |=> apb_rsp.prdata[CTRL_START_BIT] == ($past(state_q) == ST_CONV))
    else $error("Busy bit wrong");

  chk_bad_addr: assert property (setup_ph && apb_req.paddr[1:0] != 2'b00 |=> apb_rsp.pready && apb_rsp.pslverr)
    else $error("Unaligned access not refused");

  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("Ready stood longer than one cycle");

  chk_irq_level: assert property (|(status_q & mask_q) |=> irq)
    else $error("Interrupt not raised");

  chk_irq_quiet: assert property (!(|(status_q & mask_q)) |=> !irq)
    else $error("Interrupt raised with nothing pending");
endmodule : adc_sel_core
`default_nettype wire

// file: logic/adc_sel_pkg.sv
// Constants, field layouts and carrier types for the converter selection and result block
`default_nettype none
package adc_sel_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT_LOW   = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH  = 8'h79;
  localparam logic [7:0] IDX_INPUT_SELECT = 8'h7C;
  localparam logic [7:0] IDX_CONTROL      = 8'h70;
  localparam logic [7:0] IDX_STATUS       = 8'h71;
  localparam logic [7:0] IDX_MASK         = 8'h72;

  localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
  localparam int         REF_HI  = 7;
  localparam int         REF_LO  = 6;
  localparam int         LADJ_BIT = 5;
  localparam int         CHAN_HI = 4;

  localparam int CTRL_START_BIT = 0;
  localparam int ST_DONE_BIT    = 0;
  localparam int ST_LOST_BIT    = 1;
  localparam int EVT_W          = 2;

  localparam int RES_W = 10;

  // Reference choices
  localparam logic [1:0] REF_PIN      = 2'b00;
  localparam logic [1:0] REF_SUPPLY   = 2'b01;
  localparam logic [1:0] REF_INT_1V1  = 2'b10;
  localparam logic [1:0] REF_INT_2V56 = 2'b11;

  // Channel/gain code landmarks
  localparam logic [4:0] CH_LAST_SINGLE = 5'b00111;
  localparam logic [4:0] CH_FIRST_VS1   = 5'b10000;
  localparam logic [4:0] CH_FIRST_VS2   = 5'b11000;
  localparam logic [4:0] CH_BANDGAP     = 5'b11110;
  localparam logic [4:0] CH_GROUND      = 5'b11111;
  localparam logic [2:0] IN_0 = 3'h0;
  localparam logic [2:0] IN_1 = 3'h1;
  localparam logic [2:0] IN_2 = 3'h2;

  typedef enum logic [1:0] {GAIN_X1 = 2'b00, GAIN_X10 = 2'b01, GAIN_X200 = 2'b10} gain_type;
  typedef enum logic [1:0] {SRC_PIN = 2'b00, SRC_BANDGAP = 2'b01, SRC_GROUND = 2'b10} source_type;

  typedef struct packed {
    logic       differential;
    logic [2:0] pos_input;
    logic [2:0] neg_input;
    gain_type   gain;
    source_type source;
  } route_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CONV = 2'b10} conv_state_type;
endpackage : adc_sel_pkg
`default_nettype wire

// file: tb/adc_mux_and_result_format_tb.sv
// Self-checking bench for the converter selection and result block
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module adc_mux_and_result_format_tb import adc_sel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  apb_req_type req      = '0;
  apb_rsp_type rsp;
  logic        sar_done;
  logic        conv_start;
  logic        irq;
  logic [9:0]  sar_code;
  logic [9:0]  raw      = 10'h000;
  logic [7:0]  dly      = 8'h10;
  logic [1:0]  ref_select;
  route_type   route;
  logic [31:0] rd;
  logic        er;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;

  adc_sel_core adc_sel_core_i (.core_clk(core_clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
    .sar_done(sar_done), .sar_code(sar_code), .conv_start(conv_start), .ref_select(ref_select),
    .route(route), .irq(irq));
  sar_model sar_model_i (.core_clk(core_clk), .nrst(nrst), .conv_start(conv_start), .raw(raw),
    .dly(dly), .sar_done(sar_done), .sar_code(sar_code));

  always #10 core_clk = ~core_clk;

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd, input logic [1:0] lo = 2'b00);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= {idx, lo};
    req.pwdata  <= wd;
    @(posedge core_clk);
    req.penable <= 1'b1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge core_clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wait_done();
    int n;
    n = 0;
    while (sar_done !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 300) miscompares++;
    repeat (3) @(posedge core_clk);
  endtask : wait_done

  // High byte over low byte as software reads them
  function automatic logic [15:0] fmt(logic [9:0] r, logic la);
    return la ? {r, 6'h00} : {6'h00, r};
  endfunction : fmt

  function automatic route_type xroute(logic [4:0] c);
    route_type r;
    r = '0;
    r.source       = (c == CH_BANDGAP) ? SRC_BANDGAP : (c == CH_GROUND) ? SRC_GROUND : SRC_PIN;
    r.differential = (c > CH_LAST_SINGLE) && (c < CH_BANDGAP);
    r.pos_input    = (c[4:3] == 2'b01) ? {1'b0, c[2], c[0]} : c[2:0];
    r.neg_input    = (c[4:3] == 2'b01) ? {1'b0, c[2], 1'b0} : (c[4:3] == 2'b10) ? IN_1 : IN_2;
    r.gain         = (c[4:3] != 2'b01) ? GAIN_X1 : c[1] ? GAIN_X200 : GAIN_X10;
    return r;
  endfunction : xroute

  // Blanks the fields that mean nothing for this kind of routing
  function automatic route_type keep(route_type r, route_type x);
    if (!x.differential) begin
      r.neg_input = '0;
      r.gain      = GAIN_X1;
    end
    if (x.source != SRC_PIN) r.pos_input = '0;
    return r;
  endfunction : keep

  task automatic chk_res(input logic [9:0] r, input logic la);
    logic [15:0] x;
    x = fmt(r, la);
    apb(1'b0, IDX_RESULT_LOW, 32'h0000_0000);
    `CHK("result_low", {24'h00_0000, x[7:0]}, rd)
    apb(1'b0, IDX_RESULT_HIGH, 32'h0000_0000);
    `CHK("result_high", {24'h00_0000, x[15:8]}, rd)
  endtask : chk_res

  initial begin
    logic [4:0]  c;
    logic [1:0]  rf;
    logic        la;
    logic [9:0]  res;
    logic [9:0]  prev;
    logic [15:0] x;
    void'($urandom(95));
    prev = 10'h000;
    la   = 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, IDX_INPUT_SELECT, 32'h0000_0000);
    `CHK("select_reset", 32'h0000_0000, rd)
    apb(1'b0, 8'h7F, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, er)
    apb(1'b0, IDX_INPUT_SELECT, 32'h0000_0000, 2'b10);
    `CHK("unaligned_err", 1'b1, er)
    apb(1'b1, IDX_MASK, 32'h0000_0000);
    for (int i = 0; i < 44; i++) begin
      c  = (i < 32) ? 5'(i) : 5'($urandom);
      rf = (c > CH_LAST_SINGLE && c < CH_BANDGAP) ? REF_INT_2V56 : 2'($urandom);
      la = 1'($urandom);
      if (i == 1) apb(1'b1, IDX_MASK, 32'h0000_0001);
      apb(1'b1, IDX_INPUT_SELECT, {24'h00_0000, rf, la, c});
      raw <= 10'($urandom);
      dly <= 8'h10 + 8'($urandom % 32);
      apb(1'b1, IDX_CONTROL, 32'h0000_0001);
      `CHK("start_pulse", 1'b1, conv_start)
      `CHK("ref_select", rf, ref_select)
      `CHK("route", keep(xroute(c), xroute(c)), keep(route, xroute(c)))
      apb(1'b1, IDX_INPUT_SELECT, {24'h00_0000, REF_INT_2V56, ~la, ~c});
      `CHK("ref_held", rf, ref_select)
      `CHK("route_held", keep(xroute(c), xroute(c)), keep(route, xroute(c)))
      x = fmt(prev, ~la);
      apb(1'b0, IDX_RESULT_HIGH, 32'h0000_0000);
      `CHK("remap_busy", {24'h00_0000, x[15:8]}, rd)
      apb(1'b0, IDX_CONTROL, 32'h0000_0000);
      `CHK("busy_run", 1'b1, rd[CTRL_START_BIT])
      wait_done();
      res = (c > CH_LAST_SINGLE && c < CH_BANDGAP) ? {~raw[9], raw[8:0]} : raw;
      `CHK("irq_set", 1'(i > 0), irq)
      apb(1'b0, IDX_STATUS, 32'h0000_0000);
      `CHK("done_flag", 1'b1, rd[ST_DONE_BIT])
      apb(1'b0, IDX_CONTROL, 32'h0000_0000);
      `CHK("busy_end", 1'b0, rd[CTRL_START_BIT])
      chk_res(res, ~la);
      apb(1'b1, IDX_STATUS, 32'h0000_0003);
      repeat (2) @(posedge core_clk);
      `CHK("irq_clear", 1'b0, irq)
      prev = res;
    end
    // Done lands in the access cycle of the low byte read that follows the start
    raw <= ~prev;
    dly <= 8'h01;
    apb(1'b1, IDX_CONTROL, 32'h0000_0001);
    x = fmt(prev, ~la);
    apb(1'b0, IDX_RESULT_LOW, 32'h0000_0000);
    `CHK("locked_low", {24'h00_0000, x[7:0]}, rd)
    repeat (3) @(posedge core_clk);
    apb(1'b0, IDX_RESULT_HIGH, 32'h0000_0000);
    `CHK("locked_high", {24'h00_0000, x[15:8]}, rd)
    apb(1'b0, IDX_STATUS, 32'h0000_0000);
    `CHK("lost_flag", 2'b10, rd[1:0])
    chk_res(prev, ~la);
    report_and_stop();
  end
endmodule : adc_mux_and_result_format_tb
`default_nettype wire

// file: tb/sar_model.sv
// Behavioural converter: answers each start with one done pulse after a set delay
`default_nettype none
module sar_model (
  input  wire logic       core_clk,    // System clock
  input  wire logic       nrst,        // Reset, active low
  input  wire logic       conv_start,  // Start pulse
  input  wire logic [9:0] raw,         // Code to hand back
  input  wire logic [7:0] dly,         // Cycles from start to done, at least 1
  output logic            sar_done,    // Done pulse
  output logic [9:0]      sar_code     // Code, valid only with done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Outside the done pulse the code toggles so a stale capture shows
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt      <= 0;
      sar_done <= 1'b0;
      sar_code <= 10'h155;
    end else begin
      sar_done <= 1'b0;
      sar_code <= ~sar_code;
      if (conv_start) begin
        cnt <= int'(dly);
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt      <= 0;
        sar_done <= 1'b1;
        sar_code <= raw;
      end
    end
  end
endmodule : sar_model
`default_nettype wire
